// ---- hdl/fba_dev.sv ----
// fba_dev: flash module end, two banks, permissions, program/erase sequencer
// assumes fba_if driven from flops by the cpu end on clk_sys
// Function
// - permission matrix gates masters per slave
// - sectors 0-11 8KB, sector 12 32KB
// - emulation bank four 4KB sectors
// - program bank word is 144 bits
// - emulation bank 72 bits, programmable during fetches
// - no instruction fetch from emulation bank
// - read other bank during program or erase
// - sequencer runs program and erase automatically
// - return 8-bit code with each 64-bit word
// - cpu checks, corrects single, flags multibit
// - error events off until bit 4 set
// - port check enables mask 0x0e000000; the cpu end tests only bit 25 and uses it to gate checking on every read
// - sector is smallest erasable unit
// - bank erase takes one sector erase time
// - program one wide word, 40 us nominal
// - capture failing address on ecc error
// - pipelined mode overlaps successive fetches
// - cpu blocks fetches in second 128KB
`timescale 1ns/10ps
`default_nettype none
module fba_dev #(
  parameter int unsigned EE_PROG_CYC   = (fba_pkg::EE_PROG_NOM_US * 1000 + fba_pkg::CLK_NS - 1) / fba_pkg::CLK_NS,
  parameter int unsigned PGM_ERASE_CYC = fba_pkg::PGM_ERASE_MS * 1000000 / fba_pkg::CLK_NS,
  parameter int unsigned EE_ERASE_CYC  = fba_pkg::EE_ERASE_MS * 1000000 / fba_pkg::CLK_NS
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic ce,
  fba_if.dev        fl,
  output logic      pgm_busy,
  output logic      ee_busy,
  output logic      op_done
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, PROG, ERASE} fba_dev_state_e;

  typedef struct packed {
    fba_dev_state_e           st;
    logic                     ready;
    logic                     rsp_v;
    logic [1:0]               rsp_st;
    logic [fba_pkg::DW-1:0]   rsp_d;
    logic [fba_pkg::EW-1:0]   rsp_e;
    logic [31:0]              rsp_a;
    logic [31:0]              prev_a;
    logic [31:0]              err_a;
    logic                     ee_op;
    logic                     bank_all;
    logic [3:0]               sec;
    logic [12:0]              word;
    logic [fba_pkg::PGM_W-1:0] data;
    logic [31:0]              cnt;
    logic [1:0]               busy;
    logic                     done;
    logic                     cerr;
  } fba_dev_s;

  fba_dev_s s_ff;
  fba_dev_s nxt_s;

  logic [fba_pkg::PGM_W-1:0] pgm_mem [fba_pkg::PGM_WORDS];
  logic [fba_pkg::PGM_WORDS-1:0] pgm_ok_ff;
  logic [fba_pkg::EE_W-1:0]  ee_mem [fba_pkg::EE_WORDS];
  logic [fba_pkg::EE_WORDS-1:0] ee_ok_ff;

  // erased word reads as all ones with a matching code
  localparam logic [fba_pkg::BEAT_W-1:0] ERASED_BEAT = {fba_pkg::ERASED_ECC, {fba_pkg::DW{1'b1}}};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    fba_pkg::fba_region_e     rg;
    fba_pkg::fba_region_e     crg;
    logic                     deny;
    logic [fba_pkg::PGM_W-1:0] pw;
    logic [fba_pkg::BEAT_W-1:0] beat;
    rg   = fba_pkg::fba_region(fl.addr);
    crg  = fba_pkg::fba_region(fl.cmd_addr);
    deny = 1'b0;
    pw   = '0;
    beat = '0;
    nxt_s        = s_ff;
    nxt_s.done   = 1'b0;
    nxt_s.cerr   = 1'b0;
    nxt_s.rsp_v  = 1'b0;
    nxt_s.prev_a = s_ff.rsp_a;
    nxt_s.ready  = fl.pipe_en || !(fl.req && s_ff.ready);
    if (fl.ecc_evt)
      nxt_s.err_a = s_ff.prev_a;
    if (fl.req && s_ff.ready)
    begin
      deny = (rg == fba_pkg::RG_NONE) || (fl.tu && !fl.priv)
             || (rg == fba_pkg::RG_EE && (fl.we || fl.tu))
             || (rg == fba_pkg::RG_EE && fl.instr);
      nxt_s.rsp_v = 1'b1;
      nxt_s.rsp_a = fl.addr;
      nxt_s.rsp_d = '0;
      nxt_s.rsp_e = '0;
      if (deny)
        nxt_s.rsp_st = fba_pkg::ST_DENIED;
      else if ((rg == fba_pkg::RG_PGM && s_ff.busy[0]) || (rg == fba_pkg::RG_EE && s_ff.busy[1]))
        nxt_s.rsp_st = fba_pkg::ST_BUSY;
      else
      begin
        nxt_s.rsp_st = fba_pkg::ST_OK;
        if (!fl.we && rg == fba_pkg::RG_PGM)
        begin
          pw   = pgm_mem[fl.addr[fba_pkg::PGM_SEC_MSB:fba_pkg::PGM_WRD_LSB]];
          beat = fl.addr[fba_pkg::PGM_HALF] ? pw[fba_pkg::PGM_W-1:fba_pkg::BEAT_W] : pw[fba_pkg::BEAT_W-1:0];
          if (!pgm_ok_ff[fl.addr[fba_pkg::PGM_SEC_MSB:fba_pkg::PGM_WRD_LSB]])
            beat = ERASED_BEAT;
        end
        else if (!fl.we)
        begin
          beat = ee_mem[fl.addr[fba_pkg::EE_SEC_MSB:fba_pkg::EE_WRD_LSB]];
          if (!ee_ok_ff[fl.addr[fba_pkg::EE_SEC_MSB:fba_pkg::EE_WRD_LSB]])
            beat = ERASED_BEAT;
        end
        nxt_s.rsp_d = beat[fba_pkg::DW-1:0];
        nxt_s.rsp_e = beat[fba_pkg::BEAT_W-1:fba_pkg::DW];
      end
    end
    unique case (s_ff.st)
      IDLE:
      begin
        if (fl.cmd_valid && (crg == fba_pkg::RG_NONE || fl.cmd_op == 2'(fba_pkg::CMD_ERASE_BANK + 2'h1)))
          nxt_s.cerr = 1'b1;
        else if (fl.cmd_valid)
        begin
          nxt_s.ee_op    = (crg == fba_pkg::RG_EE);
          nxt_s.bank_all = (fl.cmd_op == fba_pkg::CMD_ERASE_BANK);
          nxt_s.data     = fl.cmd_data;
          nxt_s.busy     = nxt_s.ee_op ? 2'b10 : 2'b01;
          if (nxt_s.ee_op)
          begin
            nxt_s.sec  = {2'b00, fl.cmd_addr[fba_pkg::EE_SEC_MSB:fba_pkg::EE_SEC_LSB]};
            nxt_s.word = {2'b00, fl.cmd_addr[fba_pkg::EE_SEC_MSB:fba_pkg::EE_WRD_LSB]};
          end
          else
          begin
            nxt_s.sec  = fba_pkg::fba_pgm_sector(fl.cmd_addr);
            nxt_s.word = fl.cmd_addr[fba_pkg::PGM_SEC_MSB:fba_pkg::PGM_WRD_LSB];
          end
          if (fl.cmd_op == fba_pkg::CMD_PROG)
          begin
            nxt_s.st  = PROG;
            nxt_s.cnt = nxt_s.ee_op ? 32'(EE_PROG_CYC - 1) : 32'(fba_pkg::PROG_CYC - 1);
          end
          else
          begin
            nxt_s.st  = ERASE;
            nxt_s.cnt = nxt_s.ee_op ? 32'(EE_ERASE_CYC - 1) : 32'(PGM_ERASE_CYC - 1);
          end
        end
      end
      PROG, ERASE:
      begin
        nxt_s.cerr = fl.cmd_valid;
        if (s_ff.cnt == 32'h0000_0000)
        begin
          nxt_s.st   = IDLE;
          nxt_s.busy = 2'b00;
          nxt_s.done = 1'b1;
        end
        else
          nxt_s.cnt = s_ff.cnt - 32'h0000_0001;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_ff       <= '0;
      s_ff.st    <= IDLE;
      s_ff.ready <= 1'b1;
    end
    else if (ce)
      s_ff <= nxt_s;
  end

  // ---------------------------------------------------------------
  // array update at end of operation
  // ---------------------------------------------------------------
  wire logic fin_prog  = ce && s_ff.st == PROG && s_ff.cnt == 32'h0000_0000;
  wire logic fin_erase = ce && s_ff.st == ERASE && s_ff.cnt == 32'h0000_0000;

  always_ff @(posedge clk_sys)
  begin
    if (fin_prog && !s_ff.ee_op)
      pgm_mem[s_ff.word] <= (pgm_ok_ff[s_ff.word] ? pgm_mem[s_ff.word] : '1) & s_ff.data;
    if (fin_prog && s_ff.ee_op)
      ee_mem[s_ff.word[10:0]] <= (ee_ok_ff[s_ff.word[10:0]] ? ee_mem[s_ff.word[10:0]] : '1)
                                 & s_ff.data[fba_pkg::EE_W-1:0];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pgm_ok_ff <= '0;
      ee_ok_ff  <= '0;
    end
    else
    begin
      if (fin_prog && !s_ff.ee_op)
        pgm_ok_ff[s_ff.word] <= 1'b1;
      if (fin_prog && s_ff.ee_op)
        ee_ok_ff[s_ff.word[10:0]] <= 1'b1;
      for (int w = 0; w < fba_pkg::PGM_WORDS; w++)
        if (fin_erase && !s_ff.ee_op
            && (s_ff.bank_all || fba_pkg::fba_pgm_sector(32'(w) << fba_pkg::PGM_WRD_LSB) == s_ff.sec))
          pgm_ok_ff[w] <= 1'b0;
      for (int w = 0; w < fba_pkg::EE_WORDS; w++)
        if (fin_erase && s_ff.ee_op && (s_ff.bank_all || 2'(w >> (fba_pkg::EE_SEC_LSB - fba_pkg::EE_WRD_LSB))
            == s_ff.sec[1:0]))
          ee_ok_ff[w] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign fl.req_ready  = s_ff.ready;
  assign fl.rsp_valid  = s_ff.rsp_v;
  assign fl.rsp_status = s_ff.rsp_st;
  assign fl.rsp_data   = s_ff.rsp_d;
  assign fl.rsp_ecc    = s_ff.rsp_e;
  assign fl.err_addr   = s_ff.err_a;
  assign fl.cmd_done   = s_ff.done;
  assign fl.cmd_err    = s_ff.cerr;
  assign pgm_busy      = s_ff.busy[0];
  assign ee_busy       = s_ff.busy[1];
  assign op_done       = s_ff.done;
endmodule : fba_dev
`default_nettype wire

// ---- hdl/fba_pkg.sv ----
// fba_pkg: constants, types and ecc function for the flash bank access block
// assumes a 100 MHz system clock; used by both ends and the bench
package fba_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS         = 10;
  localparam int unsigned PROG_NOM_US    = 40;
  localparam int unsigned PROG_MAX_US    = 300;
  localparam int unsigned EE_PROG_NOM_US = 47;
  localparam int unsigned PGM_ERASE_MS   = 16;
  localparam int unsigned EE_ERASE_MS    = 14;
  localparam int unsigned PROG_CYC       = (PROG_NOM_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PROG_MAX_CYC   = (PROG_MAX_US * 1000) / CLK_NS;
  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [31:0] PGM_END   = 32'h0001_FFFF;
  localparam logic [31:0] PGM_SEC12 = 32'h0001_8000;
  localparam logic [31:0] EE_BASE   = 32'hF020_0000;
  localparam logic [31:0] EE_END    = 32'hF020_3FFF;
  localparam logic [31:0] SPEC_LO   = 32'h0002_0000;
  localparam logic [31:0] SPEC_HI   = 32'h0003_FFFF;
  localparam logic [3:0]  LAST_SEC  = 4'hC;
  localparam int unsigned PGM_SEC_LSB = 13;
  localparam int unsigned PGM_SEC_MSB = 16;
  localparam int unsigned EE_SEC_LSB  = 12;
  localparam int unsigned EE_SEC_MSB  = 13;
  localparam int unsigned PGM_WRD_LSB = 4;
  localparam int unsigned PGM_HALF    = 3;
  localparam int unsigned EE_WRD_LSB  = 3;
  // ---------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------
  localparam int unsigned DW        = 64;
  localparam int unsigned EW        = 8;
  localparam int unsigned BEAT_W    = DW + EW;
  localparam int unsigned PGM_W     = 2 * BEAT_W;
  localparam int unsigned EE_W      = BEAT_W;
  localparam int unsigned PGM_WORDS = 8192;
  localparam int unsigned EE_WORDS  = 2048;
  // ---------------------------------------------------------------
  // host control bits and register indices
  // ---------------------------------------------------------------
  localparam int unsigned PERF_EVT_BIT   = 4;
  localparam logic [31:0] AUX_CHK_MASK   = 32'h0E00_0000;
  localparam int unsigned AUX_INSTR_BIT  = 25;
  localparam int unsigned CTL_PIPE_BIT   = 0;
  localparam logic [2:0]  REG_PERF       = 3'h0;
  localparam logic [2:0]  REG_AUX        = 3'h1;
  localparam logic [2:0]  REG_CTL        = 3'h2;
  localparam logic [2:0]  REG_ERRCNT     = 3'h3;
  localparam logic [2:0]  REG_ERRADDR    = 3'h4;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RG_NONE, RG_PGM, RG_EE} fba_region_e;
  typedef enum logic [1:0] {ST_OK, ST_DENIED, ST_BUSY} fba_status_e;
  typedef enum logic [1:0] {CMD_PROG, CMD_ERASE_SEC, CMD_ERASE_BANK} fba_cmd_e;
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic fba_region_e fba_region(input logic [31:0] a);
    if (a <= PGM_END)
      return RG_PGM;
    if (a >= EE_BASE && a <= EE_END)
      return RG_EE;
    return RG_NONE;
  endfunction : fba_region

  function automatic logic [3:0] fba_pgm_sector(input logic [31:0] a);
    if (a >= PGM_SEC12)
      return LAST_SEC;
    return a[PGM_SEC_MSB:PGM_SEC_LSB];
  endfunction : fba_pgm_sector

  // hamming check bits over positions skipping powers of two, bit 7 overall
  function automatic logic [EW-1:0] fba_ecc(input logic [DW-1:0] d);
    logic [EW-1:0] c;
    logic [7:0]    p;
    c = '0;
    p = 8'h03;
    for (int i = 0; i < DW; i++)
    begin
      if (d[i])
        c[EW-2:0] = c[EW-2:0] ^ p[EW-2:0];
      p = p + 8'h01;
      if ((p & (p - 8'h01)) == 8'h00)
        p = p + 8'h01;
    end
    c[EW-1] = (^d) ^ (^c[EW-2:0]);
    return c;
  endfunction : fba_ecc

  localparam logic [EW-1:0] ERASED_ECC = fba_ecc('1);
endpackage : fba_pkg

// ---- hdl/fba_if.sv ----
// fba_if: link between the cpu end and the flash access end
// assumes both ends share clk_sys
`timescale 1ns/10ps
`default_nettype none
interface fba_if;
  logic         req, req_ready, we, instr, tu, priv, pipe_en;
  logic [31:0]  addr, err_addr, cmd_addr;
  logic         rsp_valid, ecc_evt, cmd_valid, cmd_done, cmd_err;
  logic [1:0]   rsp_status, cmd_op;
  logic [63:0]  rsp_data;
  logic [7:0]   rsp_ecc;
  logic [143:0] cmd_data;
  modport dev  (input req, we, instr, tu, priv, addr, pipe_en, cmd_valid, cmd_op, cmd_addr, cmd_data, ecc_evt,
                output req_ready, rsp_valid, rsp_status, rsp_data, rsp_ecc, err_addr, cmd_done, cmd_err);
  modport host (output req, we, instr, tu, priv, addr, pipe_en, cmd_valid, cmd_op, cmd_addr, cmd_data, ecc_evt,
                input req_ready, rsp_valid, rsp_status, rsp_data, rsp_ecc, err_addr, cmd_done, cmd_err);
endinterface : fba_if
`default_nettype wire

// ---- hdl/fba_host.sv ----
// fba_host: cpu end, issues accesses and commands, checks ecc per beat
// assumes fba_dev on the other side of fba_if, same clock
`timescale 1ns/10ps
`default_nettype none
module fba_host (
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic          ce,
  fba_if.host                fl,
  input  wire logic [2:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_we,
  input  wire logic          reg_re,
  output logic      [31:0]   reg_rdata,
  input  wire logic          u_req,
  input  wire logic          u_we,
  input  wire logic          u_instr,
  input  wire logic          u_tu,
  input  wire logic          u_priv,
  input  wire logic [31:0]   u_addr,
  output logic               u_idle,
  output logic               u_rsp_valid,
  output logic      [1:0]    u_rsp_status,
  output logic      [63:0]   u_rdata,
  output logic               u_sb_err,
  output logic               u_mb_err,
  input  wire logic          u_cmd_valid,
  input  wire logic [1:0]    u_cmd_op,
  input  wire logic [31:0]   u_cmd_addr,
  input  wire logic [143:0]  u_cmd_data,
  output logic               u_cmd_done,
  output logic               u_cmd_err
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic req; logic we; logic instr; logic tu; logic priv; logic lw;
    logic [31:0] addr;
    logic cmd_v; logic [1:0] cmd_op; logic [31:0] cmd_a; logic [143:0] cmd_d;
    logic evt; logic [31:0] perf; logic [31:0] aux; logic [31:0] ctl;
    logic [15:0] sb_cnt; logic [15:0] mb_cnt; logic [31:0] rdata;
    logic rsp_v; logic [1:0] rsp_st; logic [63:0] rsp_d; logic sb; logic mb;
    logic idle; logic cdone; logic cerr;
  } fba_host_s;

  fba_host_s s_ff;
  fba_host_s nxt_s;

  // flip the data bit sitting at hamming position syn
  function automatic logic [63:0] fba_fix(input logic [63:0] d, input logic [6:0] syn);
    logic [7:0]  p;
    logic [63:0] r;
    r = d;
    p = 8'h03;
    for (int i = 0; i < fba_pkg::DW; i++)
    begin
      if (p[6:0] == syn)
        r[i] = ~d[i];
      p = p + 8'h01;
      if ((p & (p - 8'h01)) == 8'h00)
        p = p + 8'h01;
    end
    return r;
  endfunction : fba_fix

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [7:0] syn;
    logic       par;
    logic       chk;
    syn = fba_pkg::fba_ecc(fl.rsp_data) ^ fl.rsp_ecc;
    par = ^{fl.rsp_data, fl.rsp_ecc};
    chk = fl.rsp_valid && fl.rsp_status == fba_pkg::ST_OK && !s_ff.lw && s_ff.aux[fba_pkg::AUX_INSTR_BIT];
    nxt_s       = s_ff;
    nxt_s.rsp_v = 1'b0;
    nxt_s.sb    = 1'b0;
    nxt_s.mb    = 1'b0;
    nxt_s.evt   = 1'b0;
    nxt_s.cmd_v = u_cmd_valid;
    nxt_s.cdone = fl.cmd_done;
    nxt_s.cerr  = fl.cmd_err;
    if (u_cmd_valid)
    begin
      nxt_s.cmd_op = u_cmd_op;
      nxt_s.cmd_a  = u_cmd_addr;
      nxt_s.cmd_d  = u_cmd_data;
    end
    if (s_ff.req && fl.req_ready)
      nxt_s.req = 1'b0;
    if (u_req && s_ff.idle)
    begin
      if (u_instr && u_addr >= fba_pkg::SPEC_LO && u_addr <= fba_pkg::SPEC_HI)
      begin
        nxt_s.rsp_v  = 1'b1;
        nxt_s.rsp_st = fba_pkg::ST_DENIED;
        nxt_s.rsp_d  = '0;
      end
      else
      begin
        nxt_s.req   = 1'b1;
        nxt_s.we    = u_we;
        nxt_s.lw    = u_we;
        nxt_s.instr = u_instr;
        nxt_s.tu    = u_tu;
        nxt_s.priv  = u_priv;
        nxt_s.addr  = u_addr;
      end
    end
    if (fl.rsp_valid)
    begin
      nxt_s.rsp_v  = 1'b1;
      nxt_s.rsp_st = fl.rsp_status;
      nxt_s.rsp_d  = fl.rsp_data;
      if (chk && par)
      begin
        nxt_s.sb     = 1'b1;
        nxt_s.rsp_d  = fba_fix(fl.rsp_data, syn[6:0]);
        nxt_s.sb_cnt = s_ff.sb_cnt + 16'h0001;
      end
      else if (chk && syn[6:0] != 7'h00)
      begin
        nxt_s.mb     = 1'b1;
        nxt_s.mb_cnt = s_ff.mb_cnt + 16'h0001;
      end
      nxt_s.evt = chk && (par || syn[6:0] != 7'h00) && s_ff.perf[fba_pkg::PERF_EVT_BIT];
    end
    nxt_s.idle = !nxt_s.req && !s_ff.req;
    if (reg_we)
    begin
      unique case (reg_addr)
        fba_pkg::REG_PERF: nxt_s.perf = reg_wdata;
        fba_pkg::REG_AUX:  nxt_s.aux  = reg_wdata;
        fba_pkg::REG_CTL:  nxt_s.ctl  = reg_wdata;
        default:           nxt_s.ctl  = s_ff.ctl;
      endcase
    end
    unique case (reg_addr)
      fba_pkg::REG_PERF:    nxt_s.rdata = s_ff.perf;
      fba_pkg::REG_AUX:     nxt_s.rdata = s_ff.aux;
      fba_pkg::REG_CTL:     nxt_s.rdata = s_ff.ctl;
      fba_pkg::REG_ERRCNT:  nxt_s.rdata = {s_ff.mb_cnt, s_ff.sb_cnt};
      fba_pkg::REG_ERRADDR: nxt_s.rdata = fl.err_addr;
      default:              nxt_s.rdata = '0;
    endcase
    if (!reg_re)
      nxt_s.rdata = '0;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_ff      <= '0;
      s_ff.idle <= 1'b1;
    end
    else if (ce)
      s_ff <= nxt_s;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign fl.req       = s_ff.req;
  assign fl.we        = s_ff.we;
  assign fl.instr     = s_ff.instr;
  assign fl.tu        = s_ff.tu;
  assign fl.priv      = s_ff.priv;
  assign fl.addr      = s_ff.addr;
  assign fl.pipe_en   = s_ff.ctl[fba_pkg::CTL_PIPE_BIT];
  assign fl.cmd_valid = s_ff.cmd_v;
  assign fl.cmd_op    = s_ff.cmd_op;
  assign fl.cmd_addr  = s_ff.cmd_a;
  assign fl.cmd_data  = s_ff.cmd_d;
  assign fl.ecc_evt   = s_ff.evt;
  assign reg_rdata    = s_ff.rdata;
  assign u_idle       = s_ff.idle;
  assign u_rsp_valid  = s_ff.rsp_v;
  assign u_rsp_status = s_ff.rsp_st;
  assign u_rdata      = s_ff.rsp_d;
  assign u_sb_err     = s_ff.sb;
  assign u_mb_err     = s_ff.mb;
  assign u_cmd_done   = s_ff.cdone;
  assign u_cmd_err    = s_ff.cerr;
endmodule : fba_host
`default_nettype wire

// ---- tb/fba_chk.sv ----
// fba_chk: assertions on the link between cpu end and flash end
// assumes fba_if signals on one clock, reset async low
`timescale 1ns/10ps
`default_nettype none
module fba_chk (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        req,
  input wire logic        req_ready,
  input wire logic        we,
  input wire logic        instr,
  input wire logic        tu,
  input wire logic        priv,
  input wire logic        pipe_en,
  input wire logic [31:0] addr,
  input wire logic        rsp_valid,
  input wire logic [1:0]  rsp_status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire tk = req && req_ready;
  wire ee = addr >= fba_pkg::EE_BASE && addr <= fba_pkg::EE_END;
  take_answer_a: assert property (tk |=> rsp_valid) else $error("no answer after take");
  answer_cause_a: assert property (rsp_valid |-> $past(tk)) else $error("answer without take");
  tu_user_a: assert property (tk && tu && !priv |=> rsp_status == 2'h1) else $error("user transfer allowed");
  ee_write_a: assert property (tk && ee && (we || tu) |=> rsp_status == 2'h1) else $error("ee write allowed");
  ee_fetch_a: assert property (tk && ee && instr |=> rsp_status == 2'h1) else $error("ee fetch allowed");
  out_map_a: assert property (tk && !ee && addr > fba_pkg::PGM_END |=> rsp_status == 2'h1) else $error("unmapped ok");
  pipe_ready_a: assert property (tk && pipe_en |=> req_ready) else $error("pipelined ready dropped");
  nopipe_gap_a: assert property (tk && !pipe_en |=> !req_ready ##1 req_ready) else $error("no idle gap");
endmodule : fba_chk
`default_nettype wire

// ---- tb/tb.sv ----
// tb: top bench, both ends joined by fba_if, random and corner accesses
// assumes fba_pkg, fba_if, fba_dev, fba_host and fba_chk compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic         clk_sys = 1'b0, nrst = 1'b0, reg_we = 1'b0, reg_re = 1'b0, u_req = 1'b0, u_we = 1'b0;
  logic         u_instr = 1'b0, u_tu = 1'b0, u_priv = 1'b0, u_cmd_valid = 1'b0, er;
  logic [2:0]   reg_addr = 3'h0;
  logic [1:0]   u_cmd_op = 2'h0, u_rsp_status, st, e;
  logic [31:0]  reg_wdata = 32'h0, u_addr = 32'h0, u_cmd_addr = 32'h0, reg_rdata, a, b, r;
  logic [63:0]  u_rdata, d;
  logic [143:0] u_cmd_data = '0, wd;
  logic         u_idle, u_rsp_valid, u_sb_err, u_mb_err, u_cmd_done, u_cmd_err, pgm_busy, ee_busy, op_done;
  logic [37:0]  tv [10] = '{{32'hF020_0000, 4'h8, 2'h1}, {32'hF020_3FF8, 4'h3, 2'h1}, {32'h0001_0000, 4'h2, 2'h1},
    {32'h0001_0000, 4'h3, 2'h0}, {32'hF020_1000, 4'h4, 2'h1}, {32'hF020_3FF8, 4'h0, 2'h0}, {32'hF020_4000, 4'h0, 2'h1},
    {32'h0002_0000, 4'h0, 2'h1}, {32'h0002_0000, 4'h4, 2'h1}, {32'h0001_FFF8, 4'h8, 2'h0}};
  int           fail_count = 0, compares = 0, n, ns;
  fba_if bus ();
  fba_dev #(.EE_PROG_CYC(20), .PGM_ERASE_CYC(20), .EE_ERASE_CYC(20)) u_fba_dev (.clk_sys, .nrst, .ce(1'b1), .fl(bus),
    .pgm_busy, .ee_busy, .op_done);
  fba_host u_fba_host (.clk_sys, .nrst, .ce(1'b1), .fl(bus), .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .u_req, .u_we, .u_instr, .u_tu, .u_priv, .u_addr, .u_idle, .u_rsp_valid, .u_rsp_status, .u_rdata, .u_sb_err,
    .u_mb_err, .u_cmd_valid, .u_cmd_op, .u_cmd_addr, .u_cmd_data, .u_cmd_done, .u_cmd_err);
  fba_chk u_fba_chk (.clk_sys, .nrst, .req(bus.req), .req_ready(bus.req_ready), .we(bus.we), .instr(bus.instr),
    .tu(bus.tu), .priv(bus.priv), .pipe_en(bus.pipe_en), .addr(bus.addr), .rsp_valid(bus.rsp_valid),
    .rsp_status(bus.rsp_status));
  always #5 clk_sys = ~clk_sys;
  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [143:0] got, input logic [143:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] ad, input logic [31:0] dt);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] ad, output logic [31:0] dt);
    @(posedge clk_sys);
    reg_re <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1 dt = reg_rdata;
  endtask : rd
  // m holds we, instr, tu, priv
  task automatic acc(input logic [31:0] ad, input logic [3:0] m);
    @(posedge clk_sys);
    u_req <= 1'b1;
    {u_we, u_instr, u_tu, u_priv} <= m;
    u_addr <= ad;
    @(posedge clk_sys);
    u_req <= 1'b0;
    #1;
    for (n = 0; n < 20 && u_rsp_valid !== 1'b1; n++) @(posedge clk_sys) #1;
    if (n == 20)
    begin
      fail_count++;
      end_sim();
    end
    st = u_rsp_status;
    d = u_rdata;
    e = {u_sb_err, u_mb_err};
  endtask : acc
  task automatic go(input logic [1:0] op, input logic [31:0] ad, input logic [143:0] dt);
    @(posedge clk_sys);
    u_cmd_valid <= 1'b1;
    u_cmd_op <= op;
    u_cmd_addr <= ad;
    u_cmd_data <= dt;
    @(posedge clk_sys);
    u_cmd_valid <= 1'b0;
    for (n = 0; n < 5000 && u_cmd_done !== 1'b1 && u_cmd_err !== 1'b1; n++) @(posedge clk_sys) #1;
    if (n == 5000)
    begin
      fail_count++;
      end_sim();
    end
    er = u_cmd_err;
  endtask : go
  initial
  begin
    a = $urandom(32'h34d9);
    repeat (6) @(posedge clk_sys);
    chk(u_idle, 1'b1);
    nrst <= 1'b1;
    // ---------------------------------------------------------------
    // erased read with checking on
    // ---------------------------------------------------------------
    wr(fba_pkg::REG_PERF, 32'h0000_0010);
    wr(fba_pkg::REG_AUX, fba_pkg::AUX_CHK_MASK);
    a = {15'h0, 13'($urandom_range(32'h17FE, 0)), 4'h0};
    acc(a, 4'h4);
    chk({st, e, d}, {2'h0, 2'h0, 64'hFFFF_FFFF_FFFF_FFFF});
    rd(fba_pkg::REG_ERRCNT, r);
    chk(r, 32'h0);
    $display("erased read done");
    // ---------------------------------------------------------------
    // permission table, unpipelined then pipelined
    // ---------------------------------------------------------------
    for (int p = 0; p < 2; p++)
    begin
      wr(fba_pkg::REG_CTL, 32'(p));
      for (int i = 0; i < 10; i++)
      begin
        acc(tv[i][37:6], tv[i][5:2]);
        chk(st, tv[i][1:0]);
      end
    end
    $display("permission table done");
    // ---------------------------------------------------------------
    // program wide word, ee program beside fetches
    // ---------------------------------------------------------------
    wr(fba_pkg::REG_AUX, 32'h0);
    wd = {16'hFFFF, $urandom, $urandom, $urandom, $urandom};
    wd[71:64] = fba_pkg::fba_ecc(wd[63:0]);
    go(2'h0, a, wd);
    chk(n >= fba_pkg::PROG_CYC - 2 && n <= fba_pkg::PROG_MAX_CYC, 1'b1);
    acc(a, 4'h4);
    chk(d, wd[63:0]);
    acc(a | 32'h8, 4'h0);
    chk(d, wd[135:72]);
    b = fba_pkg::EE_BASE | {18'h0, 11'($urandom), 3'h0};
    @(posedge clk_sys);
    u_cmd_valid <= 1'b1;
    u_cmd_op <= 2'h0;
    u_cmd_addr <= b;
    u_cmd_data <= wd;
    @(posedge clk_sys);
    u_cmd_valid <= 1'b0;
    acc(a, 4'h4);
    chk({st, d}, {2'h0, wd[63:0]});
    acc(b, 4'h0);
    chk(st, fba_pkg::ST_BUSY);
    repeat (30) @(posedge clk_sys);
    acc(b, 4'h0);
    chk({st, d}, {2'h0, wd[63:0]});
    $display("program done");
    // ---------------------------------------------------------------
    // sector erase, bank erase, bad command
    // ---------------------------------------------------------------
    go(2'h0, 32'h0001_FFF0, wd ^ 144'h1);
    wr(fba_pkg::REG_AUX, fba_pkg::AUX_CHK_MASK);
    acc(32'h0001_FFF0, 4'h4);
    chk({e, d}, {2'h2, wd[63:0]});
    rd(fba_pkg::REG_ERRADDR, r);
    chk(r, 32'h0001_FFF0);
    go(2'h1, fba_pkg::PGM_SEC12, '0);
    ns = n;
    acc(32'h0001_FFF0, 4'h0);
    chk(d, 64'hFFFF_FFFF_FFFF_FFFF);
    acc(a, 4'h0);
    chk(d, wd[63:0]);
    go(2'h2, 32'h0, '0);
    chk(n, ns);
    acc(a, 4'h0);
    chk(d, 64'hFFFF_FFFF_FFFF_FFFF);
    go(2'h3, 32'h0, '0);
    chk(er, 1'b1);
    rd(3'h7, r);
    chk(r, 32'h0);
    $display("erase done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
